// ---- inc/spmi_pkg.sv ----
// constants and state type of the switch port media interface
package spmi_pkg;
    // port modes and speeds
    localparam logic [1:0] MODE_MII = 2'h0;
    localparam logic [1:0] MODE_RMII = 2'h1;
    localparam logic [1:0] MODE_RGMII = 2'h2;
    localparam logic [1:0] SPD_10 = 2'h0;
    localparam logic [1:0] SPD_100 = 2'h1;
    localparam logic [1:0] SPD_1000 = 2'h2;
    // system clock and the link clock this block generates itself
    localparam int CLK_PERIOD_NS = 50;
    localparam int LINK_PERIOD_NS = 400;
    localparam int HALF_CYC = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam logic [2:0] HALF_LAST = 3'(HALF_CYC - 1);
    // rmii at 10 Mbit/s repeats every dibit this many reference clocks
    localparam int RMII_REP = 10;
    localparam logic [3:0] REP_LAST = 4'(RMII_REP - 1);
    // symbols per byte, minus one, and the buffer full count
    localparam logic [1:0] NIB_LAST = 2'h1;
    localparam logic [1:0] DIB_LAST = 2'h3;
    localparam logic [1:0] BUF_FULL = 2'h2;

    typedef struct packed {
        logic [1:0] mode;
        logic phy;
        logic [1:0] spd;
        logic dly;
        logic refout;
        logic an;
        logic [1:0] sgspd;
        logic [2:0] tcs;
        logic [2:0] rcs;
        logic [3:0] rd1;
        logic [3:0] rd2;
        logic dv1;
        logic dv2;
        logic er1;
        logic er2;
        logic [2:0] div;
        logic gclk;
        logic gclk_d;
        logic [3:0] txd;
        logic ten;
        logic ter;
        logic tact;
        logic tbe;
        logic tco;
        logic tcoe;
        logic rco;
        logic rcoe;
        logic [7:0] tsh;
        logic [1:0] tph;
        logic [3:0] trep;
        logic [1:0][7:0] bd;
        logic [1:0] be;
        logic wp;
        logic rp;
        logic [1:0] cnt;
        logic rdy;
        logic [7:0] rsh;
        logic [1:0] rph;
        logic rerr;
        logic ract;
        logic rctl;
        logic [3:0] rrep;
        logic [7:0] rdat;
        logic rval;
        logic rer;
        logic idl;
    } spmi_st_t;

    // reset image: idle reads high; with no frame active the settings latch at the first edge after release
    localparam spmi_st_t ST_RST = '{idl: 1'b1, default: '0};
endpackage

// ---- tb/spmi_phy_model.sv ----
// far-side mii transceiver model: free-running clocks, receive frames, transmit capture
`timescale 1ns/1ps
module spmi_phy_model
    import spmi_pkg::*;
(
    input wire logic txclk_w_i, // transmit clock wire level
    input wire logic rxclk_w_i, // receive clock wire level
    input wire logic [3:0] txd_i, // nibble from the port
    input wire logic tx_en_i, // frame active from the port
    input wire logic tx_er_i, // send error from the port
    output logic txclk_o, // own transmit clock
    output logic rxclk_o, // own receive clock
    output logic [3:0] rxd_o, // nibble to the port
    output logic rx_dv_o, // frame active to the port
    output logic rx_er_o, // receive error to the port
    output logic cap_valid_o, // captured byte strobe
    output logic [8:0] cap_byte_o // error flag and byte
);
    logic [8:0] rxq[$];
    logic [8:0] cur;
    logic [3:0] lo;
    logic lo_er;
    logic half;
    logic rhalf;
    initial
    begin
        {txclk_o, rxclk_o, rx_dv_o, rx_er_o, cap_valid_o, half, rhalf} = 7'h00;
        rxd_o = 4'h5;
        cap_byte_o = 9'h000;
        #137;
        forever #200 rxclk_o = ~rxclk_o;
    end
    // crystal clocks run free, the receive clock 137 ns behind the transmit clock, whose edges fall on system clock falling edges
    always #200 txclk_o = ~txclk_o;
    // data taken at the rising edge, low nibble first
    always @(posedge txclk_w_i)
    begin
        if (tx_en_i !== 1'b1)
            half = 1'b0;
        else if (!half)
        begin
            lo = txd_i;
            lo_er = tx_er_i;
            half = 1'b1;
        end
        else
        begin
            cap_byte_o = {lo_er | tx_er_i, txd_i, lo};
            cap_valid_o = 1'b1;
            half = 1'b0;
        end
    end
    always @(negedge txclk_w_i) cap_valid_o = 1'b0;
    // receive nibbles launched at the falling edge; idle data keeps toggling
    always @(negedge rxclk_w_i)
    begin
        if (rhalf)
        begin
            rxd_o = cur[7:4];
            rhalf = 1'b0;
        end
        else if (rxq.size() > 0)
        begin
            cur = rxq.pop_front();
            {rx_er_o, rxd_o, rx_dv_o, rhalf} = {cur[8], cur[3:0], 2'b11};
        end
        else
            {rx_dv_o, rx_er_o, rxd_o} = {2'b00, ~rxd_o};
    end
endmodule

// ---- tb/spmi_port_tb.sv ----
// self-checking bench of the port media interface against a queue model
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin err_total++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module spmi_port_tb;
    import spmi_pkg::*;
    logic clk_i = 0, srst_i = 1, ce_i = 1, cfg_phy_role_i = 0, cfg_rgmii_dly_i = 0;
    logic cfg_refclk_out_i = 0, cfg_sgmii_an_i = 0, tx_err_i = 0, tx_valid_i = 0;
    logic [1:0] cfg_mode_i = MODE_MII, cfg_speed_i = SPD_100, cfg_sgmii_speed_i = SPD_10;
    logic [7:0] tx_data_i = 8'h00, rx_data_o;
    logic tx_ready_o, rx_err_o, rx_valid_o, txclk_o, txclk_oe_o, rxclk_o, rxclk_oe_o;
    logic tx_en_o, tx_er_o, rx_dv_w, rx_er_w, sgmii_an_o, idle_o, p_txclk, p_rxclk, cap_v;
    logic [3:0] txd_o, rxd_w;
    logic [1:0] sgmii_speed_o;
    logic [8:0] cap_b, exp_t, exp_r;
    logic [8:0] txq[$];
    logic [8:0] rxq[$];
    logic [31:0] seed = 32'hb98c;
    int err_total = 0, checked = 0, stalls, n;
    wire txclk_w = txclk_oe_o ? txclk_o : p_txclk;
    wire rxclk_w = rxclk_oe_o ? rxclk_o : p_rxclk;
    always #25 clk_i = ~clk_i;
    spmi_port spmi_port_inst (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
        .cfg_mode_i(cfg_mode_i), .cfg_phy_role_i(cfg_phy_role_i), .cfg_speed_i(cfg_speed_i),
        .cfg_rgmii_dly_i(cfg_rgmii_dly_i), .cfg_refclk_out_i(cfg_refclk_out_i),
        .cfg_sgmii_an_i(cfg_sgmii_an_i), .cfg_sgmii_speed_i(cfg_sgmii_speed_i),
        .tx_data_i(tx_data_i), .tx_err_i(tx_err_i), .tx_valid_i(tx_valid_i),
        .tx_ready_o(tx_ready_o), .rx_data_o(rx_data_o), .rx_err_o(rx_err_o),
        .rx_valid_o(rx_valid_o), .txclk_i(txclk_w), .txclk_o(txclk_o),
        .txclk_oe_o(txclk_oe_o), .rxclk_i(rxclk_w), .rxclk_o(rxclk_o),
        .rxclk_oe_o(rxclk_oe_o), .txd_o(txd_o), .tx_en_o(tx_en_o), .tx_er_o(tx_er_o),
        .rxd_i(rxd_w), .rx_dv_i(rx_dv_w), .rx_er_i(rx_er_w), .sgmii_an_o(sgmii_an_o),
        .sgmii_speed_o(sgmii_speed_o), .idle_o(idle_o));
    spmi_phy_model phy_inst (.txclk_w_i(txclk_w), .rxclk_w_i(rxclk_w), .txd_i(txd_o),
        .tx_en_i(tx_en_o), .tx_er_i(tx_er_o), .txclk_o(p_txclk), .rxclk_o(p_rxclk),
        .rxd_o(rxd_w), .rx_dv_o(rx_dv_w), .rx_er_o(rx_er_w), .cap_valid_o(cap_v),
        .cap_byte_o(cap_b));
    function automatic logic [31:0] lfsr();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic bail(input string what);
        err_total++;
        $display("[FAIL] %s expected done seen timeout", what);
        stop_test();
    endtask
    // ****************************************
    // model side: expected bytes leave the queues in order
    // ****************************************
    always @(posedge cap_v)
    begin
        if (txq.size() == 0)
            `CHK("tx extra byte", 9'h000, cap_b)
        else
        begin
            exp_t = txq.pop_front();
            `CHK("tx byte", exp_t, cap_b)
        end
    end
    always @(negedge clk_i)
    begin
        if (rx_valid_o === 1'b1 && rxq.size() > 0)
        begin
            exp_r = rxq.pop_front();
            `CHK("rx byte", exp_r, {rx_err_o, rx_data_o})
        end
        else if (rx_valid_o === 1'b1)
            `CHK("rx extra byte", 9'h000, {rx_err_o, rx_data_o})
    end
    // ****************************************
    // drivers
    // ****************************************
    task automatic wait_idle();
        n = 0;
        while ((idle_o !== 1'b1 || txq.size() > 0 || rxq.size() > 0) && n < 4000)
        begin
            @(negedge clk_i);
            n++;
        end
        if (n >= 4000)
            bail("idle");
        repeat (3) @(negedge clk_i);
    endtask
    task automatic send_tx(input logic [7:0] d, input logic e);
        {tx_valid_i, tx_data_i, tx_err_i} = {1'b1, d, e};
        n = 0;
        while (tx_ready_o !== 1'b1 && n < 400)
        begin
            @(negedge clk_i);
            n++;
            stalls++;
        end
        if (n >= 400)
            bail("tx ready");
        txq.push_back({e, d});
        @(negedge clk_i);
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    logic [5:0] cfgs[6] = '{6'h00, 6'h08, 6'h1c, 6'h10, 6'h28, 6'h2c};
    logic [1:0] oe_exp;
    initial
    begin
        repeat (10) @(negedge clk_i);
        srst_i = 0;
        repeat (3) @(negedge clk_i);
        `CHK("ready after reset", 1'b1, tx_ready_o)
        // {mode, phy, ref, pad} per entry; clock direction follows mode and role, in rmii mode and ref
        foreach (cfgs[i])
        begin
            {cfg_mode_i, cfg_phy_role_i, cfg_refclk_out_i} = cfgs[i][5:2];
            {cfg_sgmii_an_i, cfg_sgmii_speed_i} = {lfsr() % 2 == 1, 2'(lfsr() % 3)};
            wait_idle();
            if (cfg_mode_i == MODE_MII)
                oe_exp = {2{cfg_phy_role_i}};
            else if (cfg_mode_i == MODE_RMII)
                oe_exp = {cfg_refclk_out_i, 1'b0};
            else
                oe_exp = {~cfg_phy_role_i, cfg_phy_role_i};
            `CHK("clock drive", oe_exp, {txclk_oe_o, rxclk_oe_o})
            `CHK("serial settings", {cfg_sgmii_an_i, cfg_sgmii_speed_i}, {sgmii_an_o, sgmii_speed_o})
        end
        $display("test clock sourcing done");
        // rgmii: the error line stays low even for an errored byte
        cfg_phy_role_i = 0;
        send_tx(8'h3c, 1'b1);
        tx_valid_i = 0;
        n = 0;
        repeat (60) @(negedge clk_i) n += int'(tx_er_o === 1'b1);
        `CHK("rgmii error line", 0, n)
        txq.delete();
        wait_idle();
        $display("test rgmii error line done");
        for (int role = 0; role < 2; role++)
        begin
            {cfg_mode_i, cfg_phy_role_i, cfg_rgmii_dly_i} = {MODE_MII, 1'(role), 1'(lfsr())};
            wait_idle();
            stalls = 0;
            for (int b = 0; b < 6; b++)
            begin
                phy_inst.rxq.push_back({b == 2, 8'(lfsr())});
                rxq.push_back(phy_inst.rxq[$]);
            end
            for (int b = 0; b < 8; b++)
            begin
                send_tx(8'(lfsr()), b == 5);
                if (b == 4 && role == 1)
                    cfg_phy_role_i = 1'b0;
                if (b == 5 && role == 1)
                    `CHK("mid-frame role held", 2'b11, {txclk_oe_o, rxclk_oe_o})
            end
            tx_valid_i = 0;
            `CHK("buffer refused", 1'b1, stalls > 0)
            wait_idle();
            `CHK("role after idle", 2'b00, {txclk_oe_o, rxclk_oe_o})
            $display("test mii data role %0d done", role);
        end
        stop_test();
    end
    initial
    begin
        #4000000;
        bail("watchdog");
    end
endmodule

// ---- verilog/spmi_port.sv ----
// per-port media interface: mii, rmii and rgmii pin mux with a byte stream user side
`timescale 1ns/1ps
module spmi_port
    import spmi_pkg::*;
(
    input wire logic clk_i, // 20 MHz system clock
    input wire logic srst_i, // synchronous reset, high
    input wire logic ce_i, // clock enable, low freezes all
    input wire logic [1:0] cfg_mode_i, // mii, rmii or rgmii
    input wire logic cfg_phy_role_i, // 1: act as phy toward a mac
    input wire logic [1:0] cfg_speed_i, // 10, 100 or 1000
    input wire logic cfg_rgmii_dly_i, // rgmii internal clock delay
    input wire logic cfg_refclk_out_i, // rmii: drive reference clock
    input wire logic cfg_sgmii_an_i, // serial port auto-negotiation
    input wire logic [1:0] cfg_sgmii_speed_i, // serial port forced speed
    input wire logic [7:0] tx_data_i, // byte to send
    input wire logic tx_err_i, // byte carries a send error
    input wire logic tx_valid_i, // byte offered
    output logic tx_ready_o, // buffer has room
    output logic [7:0] rx_data_o, // received byte
    output logic rx_err_o, // received byte errored
    output logic rx_valid_o, // one-cycle receive strobe
    input wire logic txclk_i, // tx_clk, ref_clk or txc pin in
    output logic txclk_o, // same pin out
    output logic txclk_oe_o, // same pin driven
    input wire logic rxclk_i, // rx_clk or rxc pin in
    output logic rxclk_o, // same pin out
    output logic rxclk_oe_o, // same pin driven
    output logic [3:0] txd_o, // transmit data pins
    output logic tx_en_o, // tx_en or tx_ctl
    output logic tx_er_o, // tx_er, low in rgmii
    input wire logic [3:0] rxd_i, // receive data pins
    input wire logic rx_dv_i, // rx_dv, crs_dv or rx_ctl
    input wire logic rx_er_i, // rx_er
    output logic sgmii_an_o, // serial port auto-negotiation on
    output logic [1:0] sgmii_speed_o, // serial port forced speed
    output logic idle_o // no frame in either direction
);
    spmi_st_t st;
    spmi_st_t nx;
    logic idle, is_rmii, is_rg, ddr, rmii10, drv_t, drv_r;
    logic g_rise, g_fall, t_rise, t_fall, r_rise, r_fall;
    logic launch, push, pop, er_eff, err_n;
    logic [1:0] n_last;
    logic [7:0] byte_u, rsh_n;

    // which clock pins this end drives
    function automatic logic f_drv_t(logic [1:0] m, logic p, logic r);
        f_drv_t = (m == MODE_MII && p) || (m == MODE_RMII && r) || (m == MODE_RGMII && !p);
    endfunction
    function automatic logic f_drv_r(logic [1:0] m, logic p);
        f_drv_r = (m == MODE_MII || m == MODE_RGMII) && p;
    endfunction

    always_comb
    begin
        nx = st;
        rsh_n = '0;
        err_n = 1'b0;
        byte_u = '0;
        pop = 1'b0;
        idle = !st.tact && st.tph == 2'h0 && !st.ract;
        is_rmii = st.mode == MODE_RMII;
        is_rg = st.mode == MODE_RGMII;
        ddr = is_rg && st.spd == SPD_1000;
        rmii10 = is_rmii && st.spd == SPD_10;
        n_last = is_rmii ? DIB_LAST : NIB_LAST;
        drv_t = f_drv_t(st.mode, st.phy, st.refout);
        drv_r = f_drv_r(st.mode, st.phy);
        // ****************************************
        // pin synchronisers
        // ****************************************
        nx.tcs = {st.tcs[1:0], txclk_i};
        nx.rcs = {st.rcs[1:0], rxclk_i};
        nx.rd1 = rxd_i;
        nx.rd2 = st.rd1;
        nx.dv1 = rx_dv_i;
        nx.dv2 = st.dv1;
        nx.er1 = rx_er_i;
        nx.er2 = st.er1;
        // ****************************************
        // settings, taken only between frames
        // ****************************************
        if (idle)
        begin
            nx.mode = cfg_mode_i;
            nx.phy = cfg_phy_role_i;
            nx.spd = cfg_speed_i;
            nx.dly = cfg_rgmii_dly_i;
            nx.refout = cfg_refclk_out_i;
            nx.an = cfg_sgmii_an_i;
            nx.sgspd = cfg_sgmii_speed_i;
        end
        // ****************************************
        // clock generation and edge detection
        // ****************************************
        g_rise = st.div == HALF_LAST && !st.gclk;
        g_fall = st.div == HALF_LAST && st.gclk;
        nx.div = (st.div == HALF_LAST) ? 3'h0 : st.div + 3'h1;
        if (st.div == HALF_LAST)
            nx.gclk = !st.gclk;
        nx.gclk_d = st.gclk;
        // the delayed copy lags the plain clock by one system cycle; coarse but keeps setup margin
        nx.tco = (is_rg && st.dly) ? st.gclk_d : st.gclk;
        nx.rco = nx.tco;
        nx.tcoe = f_drv_t(nx.mode, nx.phy, nx.refout);
        nx.rcoe = f_drv_r(nx.mode, nx.phy);
        t_rise = drv_t ? g_rise : (st.tcs[1] && !st.tcs[2]);
        t_fall = drv_t ? g_fall : (!st.tcs[1] && st.tcs[2]);
        // rmii has one shared reference on the transmit clock pin
        r_rise = is_rmii ? t_rise : (drv_r ? g_rise : (st.rcs[1] && !st.rcs[2]));
        r_fall = is_rmii ? t_fall : (drv_r ? g_fall : (!st.rcs[1] && st.rcs[2]));
        // ****************************************
        // transmit: data launched away from the sampling edge
        // ****************************************
        launch = t_fall || (ddr && t_rise && st.tph != 2'h0);
        if (launch)
        begin
            if (st.trep != 4'h0)
                nx.trep = st.trep - 4'h1;
            else
            begin
                nx.trep = rmii10 ? REP_LAST : 4'h0;
                if (st.tph == 2'h0 && st.cnt == 2'h0)
                begin
                    nx.tact = 1'b0;
                    nx.tbe = 1'b0;
                    nx.txd = 4'h0;
                end
                else
                begin
                    byte_u = (st.tph == 2'h0) ? st.bd[st.rp] : st.tsh;
                    if (st.tph == 2'h0)
                    begin
                        nx.tbe = st.be[st.rp];
                        pop = 1'b1;
                    end
                    nx.tact = 1'b1;
                    nx.txd = is_rmii ? {2'h0, byte_u[1:0]} : byte_u[3:0];
                    nx.tsh = is_rmii ? {2'h0, byte_u[7:2]} : {4'h0, byte_u[7:4]};
                    nx.tph = (st.tph == n_last) ? 2'h0 : st.tph + 2'h1;
                end
                nx.ten = nx.tact;
            end
        end
        // rgmii control line carries enable xor error on the falling half
        if (is_rg && t_rise)
            nx.ten = nx.tact ^ nx.tbe;
        nx.ter = is_rg ? 1'b0 : nx.tbe;
        // ****************************************
        // two-entry transmit buffer
        // ****************************************
        push = tx_valid_i && st.rdy;
        if (push)
        begin
            nx.bd[st.wp] = tx_data_i;
            nx.be[st.wp] = tx_err_i;
            nx.wp = !st.wp;
        end
        if (pop)
            nx.rp = !st.rp;
        nx.cnt = st.cnt + {1'b0, push} - {1'b0, pop};
        nx.rdy = nx.cnt != BUF_FULL;
        // ****************************************
        // receive
        // ****************************************
        er_eff = is_rg ? 1'b0 : st.er2;
        nx.rval = 1'b0;
        if (r_rise)
        begin
            nx.rctl = st.dv2;
            if (!st.dv2)
            begin
                nx.ract = 1'b0;
                nx.rph = 2'h0;
                nx.rerr = 1'b0;
                nx.rrep = 4'h0;
            end
            else if (st.rrep != 4'h0)
                nx.rrep = st.rrep - 4'h1;
            else
            begin
                nx.ract = 1'b1;
                nx.rrep = rmii10 ? REP_LAST : 4'h0;
                if (ddr)
                    nx.rsh = {4'h0, st.rd2};
                else
                begin
                    rsh_n = is_rmii ? {st.rd2[1:0], st.rsh[7:2]} : {st.rd2, st.rsh[7:4]};
                    err_n = st.rerr || er_eff;
                    nx.rsh = rsh_n;
                    if (st.rph == n_last)
                    begin
                        nx.rdat = rsh_n;
                        nx.rer = err_n;
                        nx.rval = 1'b1;
                        nx.rph = 2'h0;
                        nx.rerr = 1'b0;
                    end
                    else
                    begin
                        nx.rph = st.rph + 2'h1;
                        nx.rerr = err_n;
                    end
                end
            end
        end
        if (r_fall && is_rg && st.ract)
        begin
            err_n = st.rerr || (st.dv2 ^ st.rctl);
            if (ddr)
            begin
                nx.rdat = {st.rd2, st.rsh[3:0]};
                nx.rer = err_n;
                nx.rval = 1'b1;
                nx.rerr = 1'b0;
            end
            else
                nx.rerr = err_n;
        end
        nx.idl = !nx.tact && nx.tph == 2'h0 && !nx.ract;
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            st <= ST_RST;
        else if (ce_i)
            st <= nx;
    end

    assign tx_ready_o = st.rdy;
    assign rx_data_o = st.rdat;
    assign rx_err_o = st.rer;
    assign rx_valid_o = st.rval;
    assign txclk_o = st.tco;
    assign txclk_oe_o = st.tcoe;
    assign rxclk_o = st.rco;
    assign rxclk_oe_o = st.rcoe;
    assign txd_o = st.txd;
    assign tx_en_o = st.ten;
    assign tx_er_o = st.ter;
    assign sgmii_an_o = st.an;
    assign sgmii_speed_o = st.sgspd;
    assign idle_o = st.idl;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    chk_mii_mac_clocks: assert property ((st.mode == MODE_MII && st.phy) |->
        (txclk_oe_o && rxclk_oe_o)) else $error("mii phy role must drive both clocks");
    chk_mii_phy_clocks: assert property ((st.mode == MODE_MII && !st.phy) |->
        (!txclk_oe_o && !rxclk_oe_o)) else $error("mii facing phy must not drive clocks");
    chk_rgmii_mac_txc: assert property ((st.mode == MODE_RGMII && !st.phy) |->
        (txclk_oe_o && !rxclk_oe_o)) else $error("rgmii mac must drive txc only");
    chk_rgmii_phy_rxc: assert property ((st.mode == MODE_RGMII && st.phy) |->
        (rxclk_oe_o && !txclk_oe_o)) else $error("rgmii phy must drive rxc only");
    chk_rmii_ref_out: assert property ((st.mode == MODE_RMII) |->
        (txclk_oe_o == st.refout && !rxclk_oe_o)) else $error("rmii reference drive wrong");
    chk_cfg_held_busy: assert property (!idle_o |=>
        $stable({st.mode, st.phy, st.spd, st.dly, st.refout, st.an, st.sgspd}))
        else $error("setting changed during a frame");
    chk_rgmii_no_txer: assert property ((st.mode == MODE_RGMII) |-> !tx_er_o)
        else $error("tx error pin driven in rgmii");
    chk_rmii_dibit: assert property ((st.mode == MODE_RMII) ##1 (st.mode == MODE_RMII)
        |-> txd_o[3:2] == 2'h0) else $error("rmii upper data pins not low");
    chk_buf_full_ready: assert property ((st.cnt == BUF_FULL) |-> !tx_ready_o)
        else $error("ready while buffer full");
    chk_rx_strobe_one: assert property (rx_valid_o && !ddr |=> !rx_valid_o)
        else $error("receive strobe longer than one cycle");
    chk_sgmii_latched: assert property ((idle_o && ce_i) |=>
        (sgmii_an_o == $past(cfg_sgmii_an_i) && sgmii_speed_o == $past(cfg_sgmii_speed_i)))
        else $error("serial port settings not taken while idle");
    chk_idle_pins_quiet: assert property (idle_o |-> (!tx_en_o && txd_o == 4'h0))
        else $error("transmit pins active while idle");
    chk_gen_clk_step: assert property ((ce_i && st.div != HALF_LAST) |=>
        (st.div == $past(st.div) + 3'h1)) else $error("clock divider skipped a step");
    chk_gen_clk_wrap: assert property ((ce_i && st.div == HALF_LAST) |=>
        (st.div == 3'h0 && st.gclk != $past(st.gclk))) else $error("clock half period wrong");
endmodule
